// file: wdsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsc_regs.svh"

// Notes on behaviour
// - without prescaler the supervisor expires after about 18 ms of its own count.
// - option register can hand the prescaler to the supervisor, up to 1:128.
// - clear op and sleep op reset supervisor count and its assigned prescaler.
// - every supervisor expiry clears the active-low timeout flag.
// - option register resets to all ones; bit 3 assign, bits 2..0 rate.
// - sleep clears supervisor, clears powerdown flag, sets timeout flag, stops oscillator.
// - pins hold their drive state throughout sleep.
// - supervisor reset is internal only; reset pin is never driven low.
// - sleep ends only on reset pin, enabled supervisor expiry or enabled interrupts.
// - peripherals on stopped phase clocks cannot wake the device.
// - reset pin wake is full reset; other wakes continue execution.
// - sleep op prefetches the instruction at the next program address.
// - wake needs the source enable set; global enable does not gate it.
// - global enable set means run next instruction then vector to 0004h.
// - pending enabled interrupt makes sleep a no-op with no side effects.
// - interrupt during or after sleep lets sleep complete, then wakes immediately.
// - expiry resets the device when running and wakes it when sleeping.
// - configuration enable bit at 0 disables the supervisor permanently.
// - flags show cause: 11 power-on, 01 supervisor reset, 00 supervisor wake.
module wdsc_top
  import wdsc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `WDSC_TIMEOUT_US * `WDSC_CLK_MHZ
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic master_reset_pin_n_i,
  input wire logic [7:0] cfg_word_i,
  input wire logic [`WDSC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sleep_op_i,
  input wire logic clear_supervisor_op_i,
  input wire logic [`WDSC_PC_W-1:0] pc_i,
  input wire wdsc_irq_s irq_enable_i,
  input wire wdsc_irq_s irq_flag_i,
  input wire logic global_irq_enable_i,
  output logic core_reset_o,
  output logic reset_pin_out_o,
  output logic reset_pin_oe_o,
  output logic osc_driver_en_o,
  output logic io_hold_o,
  output logic sleeping_o,
  output logic wake_o,
  output logic irq_vector_req_o,
  output logic [`WDSC_PC_W-1:0] vector_addr_o,
  output logic [`WDSC_PC_W-1:0] prefetch_addr_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o,
  output logic [7:0] option_o
);

  generate
    if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
      $error("TIMEOUT_CYCLES must be at least two");
    end
  endgenerate

  wdsc_state_e state_reg;
  wdsc_state_e state_next;
  logic master_reset_pin_n_meta_reg;
  logic master_reset_pin_n_sync_reg;
  logic [7:0] option_reg;
  logic timeout_flag_n_reg;
  logic powerdown_flag_n_reg;
  logic core_reset_reg;
  logic osc_en_reg;
  logic io_hold_reg;
  logic sleeping_reg;
  logic wake_reg;
  logic vector_req_reg;
  logic [`WDSC_PC_W-1:0] prefetch_reg;
  logic [7:0] rdata_reg;
  logic pin_oe_reg;
  logic [`WDSC_PC_W-1:0] vector_addr_reg;

  logic master_reset_pin_n_low;
  logic sup_enable;
  logic irq_pending;
  logic sleep_take;
  logic clear_take;
  logic sup_clear;
  logic pre_tick;
  logic expire;
  logic expire_reset;
  logic expire_wake;
  logic irq_wake;
  logic option_reset;

  // reset pin is asynchronous to the core clock; first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      master_reset_pin_n_meta_reg <= 1'b1;
      master_reset_pin_n_sync_reg <= 1'b1;
    end else begin
      master_reset_pin_n_meta_reg <= master_reset_pin_n_i;
      master_reset_pin_n_sync_reg <= master_reset_pin_n_meta_reg;
    end
  end

  assign master_reset_pin_n_low = !master_reset_pin_n_sync_reg;
  assign sup_enable = cfg_word_i[`WDSC_CFG_SUP_EN_BIT];

  // only sources still clocked in sleep are wired in; the timer flag is not
  // individual enables gate, global enable does not
  assign irq_pending = |(irq_enable_i & irq_flag_i);

  // sleep with an enabled interrupt already pending completes as a no-op
  assign sleep_take = (state_reg == WDSC_RUN) && sleep_op_i && !irq_pending
                      && !master_reset_pin_n_low;
  assign clear_take = (state_reg == WDSC_RUN) && clear_supervisor_op_i && !master_reset_pin_n_low;

  // a device reset also restarts the supervisor from zero
  assign sup_clear = sleep_take || clear_take || master_reset_pin_n_low;

  wdsc_prescaler u_prescaler (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clr_i(sup_clear),
    .assign_i(option_reg[`WDSC_OPT_ASSIGN_BIT]),
    .rate_i(option_reg[`WDSC_OPT_RATE_HI:`WDSC_OPT_RATE_LO]),
    .tick_o(pre_tick)
  );

  // the count keeps running in sleep because it never depends on the oscillator
  wdsc_period_cnt #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_period (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clr_i(sup_clear),
    .run_i(sup_enable),
    .tick_i(pre_tick),
    .expire_o(expire)
  );

  // expiry resets when running, wakes when sleeping
  assign expire_reset = expire && (state_reg == WDSC_RUN);
  assign expire_wake = expire && (state_reg == WDSC_SLEEP);
  assign irq_wake = (state_reg == WDSC_SLEEP) && irq_pending && !master_reset_pin_n_low;

  // every reset source returns the option register to all ones
  assign option_reset = master_reset_pin_n_low || expire_reset;

  // power state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WDSC_RUN: begin
        if (sleep_take) begin
          state_next = WDSC_SLEEP;
        end
      end
      WDSC_SLEEP: begin
        // only the reset pin, expiry or an enabled source leaves sleep
        if (master_reset_pin_n_low || expire_wake || irq_wake) begin
          state_next = WDSC_RUN;
        end
      end
      default: begin
        state_next = WDSC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= WDSC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs that mirror the power state, kept as their own flops
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sleeping_reg <= 1'b0;
      osc_en_reg <= 1'b1;
      io_hold_reg <= 1'b0;
    end else begin
      sleeping_reg <= (state_next == WDSC_SLEEP);
      osc_en_reg <= (state_next != WDSC_SLEEP);
      io_hold_reg <= (state_next == WDSC_SLEEP);
    end
  end

  // timeout flag: expiry wins over any set in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      timeout_flag_n_reg <= 1'b1;
    end else if (expire) begin
      timeout_flag_n_reg <= 1'b0;
    end else if (clear_take || sleep_take) begin
      timeout_flag_n_reg <= 1'b1;
    end
  end

  // powerdown flag: untouched by expiry and by the reset pin
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      powerdown_flag_n_reg <= 1'b1;
    end else if (sleep_take) begin
      powerdown_flag_n_reg <= 1'b0;
    end else if (clear_take) begin
      powerdown_flag_n_reg <= 1'b1;
    end
  end

  // timer option control, written over the register port
  always_ff @(posedge core_clk_i) begin
    if (srst_i || option_reset) begin
      option_reg <= `WDSC_OPTION_RST;
    end else if (reg_we_i && (reg_addr_i == `WDSC_OPTION_OFS)) begin
      option_reg <= reg_wdata_i;
    end
  end

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `WDSC_OPTION_OFS: begin
          rdata_reg <= option_reg;
        end
        `WDSC_CONFIG_OFS: begin
          rdata_reg <= cfg_word_i;
        end
        `WDSC_STATUS_OFS: begin
          rdata_reg <= 8'h00;
          rdata_reg[`WDSC_STAT_TO_BIT] <= timeout_flag_n_reg;
          rdata_reg[`WDSC_STAT_PD_BIT] <= powerdown_flag_n_reg;
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // internal reset: held while the pin is low, one pulse on running expiry
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      core_reset_reg <= 1'b0;
    end else begin
      core_reset_reg <= master_reset_pin_n_low || expire_reset;
    end
  end

  // the reset pin is an input only; the supervisor never pulls it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= 1'b0;
    end
  end

  // wake without reset: core continues with the prefetched instruction
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wake_reg <= 1'b0;
      vector_req_reg <= 1'b0;
    end else begin
      wake_reg <= (expire_wake || irq_wake) && !master_reset_pin_n_low;
      // vector only for interrupts, and only with global enable set
      vector_req_reg <= irq_wake && global_irq_enable_i;
    end
  end

  // vector address sits in a flop so every output leaves a register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      vector_addr_reg <= `WDSC_IRQ_VECTOR;
    end else begin
      vector_addr_reg <= `WDSC_IRQ_VECTOR;
    end
  end

  // next address is latched when sleep really executes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prefetch_reg <= '0;
    end else if (sleep_take) begin
      prefetch_reg <= pc_i + `WDSC_PC_STEP;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign core_reset_o = core_reset_reg;
  assign reset_pin_out_o = pin_oe_reg;
  assign reset_pin_oe_o = pin_oe_reg;
  assign osc_driver_en_o = osc_en_reg;
  assign io_hold_o = io_hold_reg;
  assign sleeping_o = sleeping_reg;
  assign wake_o = wake_reg;
  assign irq_vector_req_o = vector_req_reg;
  assign vector_addr_o = vector_addr_reg;
  assign prefetch_addr_o = prefetch_reg;
  assign timeout_flag_n_o = timeout_flag_n_reg;
  assign powerdown_flag_n_o = powerdown_flag_n_reg;
  assign option_o = option_reg;

endmodule

`default_nettype wire

// file: wdsc_regs.svh
`ifndef WDSC_REGS_SVH
`define WDSC_REGS_SVH

// register addresses on the plain register port
`define WDSC_ADDR_W 14
`define WDSC_OPTION_OFS 14'h0081
`define WDSC_CONFIG_OFS 14'h2007
`define WDSC_STATUS_OFS 14'h0003

// timer option control layout and reset value
`define WDSC_OPTION_RST 8'hFF
`define WDSC_OPT_ASSIGN_BIT 3
`define WDSC_OPT_RATE_HI 2
`define WDSC_OPT_RATE_LO 0

// configuration word layout
`define WDSC_CFG_SUP_EN_BIT 2

// status layout: both flags are active low
`define WDSC_STAT_PD_BIT 3
`define WDSC_STAT_TO_BIT 4

// program counter width and interrupt vector
`define WDSC_PC_W 13
`define WDSC_IRQ_VECTOR 13'h0004
`define WDSC_PC_STEP 13'h0001

// nominal supervisor period without prescaler, and core clock rate
`define WDSC_TIMEOUT_US 18000
`define WDSC_CLK_MHZ 10

`endif

// file: wdsc_pkg.sv
package wdsc_pkg;

  // power state of the device
  typedef enum logic [1:0] {
    WDSC_RUN = 2'b00,
    WDSC_SLEEP = 2'b01
  } wdsc_state_e;

  // interrupt sources able to wake the device from sleep
  typedef struct packed {
    logic edge_irq_pin;
    logic port_change;
    logic eeprom_done;
  } wdsc_irq_s;

endpackage

// file: wdsc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module wdsc_prescaler (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clr_i,
  input wire logic assign_i,
  input wire logic [2:0] rate_i,
  output logic tick_o
);

  logic [6:0] div_reg;
  logic [6:0] mask;

  // free running divider, cleared together with the supervisor count
  always_ff @(posedge core_clk_i) begin
    if (srst_i || clr_i) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  // rate n gives one tick every 2^n cycles; unassigned means 1:1
  always_comb begin
    mask = 7'h00;
    if (assign_i) begin
      mask = 7'((8'h01 << rate_i) - 8'h01);
    end
    tick_o = ((div_reg & mask) == mask) && !clr_i;
  end

endmodule

`default_nettype wire

// file: wdsc_period_cnt.sv
`timescale 1ns/1ps
`default_nettype none

module wdsc_period_cnt #(
  parameter int CYCLES = 180000
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic tick_i,
  output logic expire_o
);

  localparam int CW = $clog2(CYCLES);

  generate
    if (CYCLES < 2) begin : g_bad
      $error("period count must be at least two");
    end
  endgenerate

  logic [CW-1:0] cnt_reg;

  assign expire_o = run_i && tick_i && !clr_i && (cnt_reg == CW'(CYCLES - 1));

  // counts prescaled ticks; wraps after expiry so a missed clear repeats
  always_ff @(posedge core_clk_i) begin
    if (srst_i || clr_i || !run_i) begin
      cnt_reg <= '0;
    end else if (expire_o) begin
      cnt_reg <= '0;
    end else if (tick_i) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

endmodule

`default_nettype wire

// file: wdsc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsc_regs.svh"
module wdsc_chk
  import wdsc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic master_reset_pin_n_i,
  input wire logic sleep_op_i,
  input wire logic clear_supervisor_op_i,
  input wire logic [`WDSC_PC_W-1:0] pc_i,
  input wire wdsc_irq_s irq_enable_i,
  input wire wdsc_irq_s irq_flag_i,
  input wire logic global_irq_enable_i,
  input wire logic core_reset_o,
  input wire logic reset_pin_out_o,
  input wire logic reset_pin_oe_o,
  input wire logic osc_driver_en_o,
  input wire logic io_hold_o,
  input wire logic sleeping_o,
  input wire logic wake_o,
  input wire logic irq_vector_req_o,
  input wire logic [`WDSC_PC_W-1:0] prefetch_addr_o,
  input wire logic timeout_flag_n_o,
  input wire logic powerdown_flag_n_o,
  input wire logic [7:0] option_o
);
  logic [3:0] pin_hist;
  logic pin_ok;
  logic pend;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // pin history keeps the tail of a pin reset out of the other checks
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_hist <= 4'h0;
    end else begin
      pin_hist <= {pin_hist[2:0], master_reset_pin_n_i};
    end
  end
  assign pin_ok = (&pin_hist) & master_reset_pin_n_i;
  assign pend = |(irq_enable_i & irq_flag_i);
  AST_PIN_IDLE: assert property (!reset_pin_oe_o && !reset_pin_out_o)
    else $error("reset pin driven");
  AST_HOLD: assert property (io_hold_o == sleeping_o && osc_driver_en_o == !sleeping_o)
    else $error("hold or oscillator wrong");
  AST_SLEEP_IN: assert property (pin_ok && sleep_op_i && !sleeping_o && !pend && !core_reset_o
    |=> sleeping_o && !powerdown_flag_n_o && timeout_flag_n_o
    && prefetch_addr_o == $past(pc_i) + 13'h0001)
    else $error("sleep entry wrong");
  AST_SLEEP_NOP: assert property (pin_ok && sleep_op_i && !sleeping_o && pend && !core_reset_o
    |=> !sleeping_o && $stable(powerdown_flag_n_o))
    else $error("pending sleep not a no-op");
  AST_IRQ_WAKE: assert property (pin_ok && sleeping_o && pend
    |=> wake_o && !sleeping_o && irq_vector_req_o == $past(global_irq_enable_i))
    else $error("interrupt wake wrong");
  AST_CLEAR: assert property (pin_ok && clear_supervisor_op_i && !sleeping_o && !core_reset_o
    |=> timeout_flag_n_o && powerdown_flag_n_o && !core_reset_o)
    else $error("clear op wrong");
  AST_EXPIRY: assert property (pin_ok && core_reset_o
    |-> !timeout_flag_n_o && option_o == 8'hFF && !sleeping_o ##1 !core_reset_o)
    else $error("running expiry wrong");
  AST_WAKE_CAUSE: assert property ($fell(sleeping_o) |-> wake_o || !pin_ok)
    else $error("sleep left without cause");
  AST_PIN_WAKE: assert property (core_reset_o |-> !wake_o)
    else $error("wake with reset");
endmodule
bind wdsc_top wdsc_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .master_reset_pin_n_i(master_reset_pin_n_i),
  .sleep_op_i(sleep_op_i), .clear_supervisor_op_i(clear_supervisor_op_i), .pc_i(pc_i),
  .irq_enable_i(irq_enable_i), .irq_flag_i(irq_flag_i),
  .global_irq_enable_i(global_irq_enable_i), .core_reset_o(core_reset_o),
  .reset_pin_out_o(reset_pin_out_o), .reset_pin_oe_o(reset_pin_oe_o),
  .osc_driver_en_o(osc_driver_en_o), .io_hold_o(io_hold_o), .sleeping_o(sleeping_o),
  .wake_o(wake_o), .irq_vector_req_o(irq_vector_req_o), .prefetch_addr_o(prefetch_addr_o),
  .timeout_flag_n_o(timeout_flag_n_o), .powerdown_flag_n_o(powerdown_flag_n_o),
  .option_o(option_o));
`default_nettype wire

// file: wdsc_irq_src.sv
`timescale 1ns/1ps
`default_nettype none
module wdsc_irq_src
  import wdsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic arm_i,
  input wire logic ack_i,
  input wire logic [3:0] delay_i,
  input wire wdsc_irq_s which_i,
  output wdsc_irq_s flag_o
);
  logic [3:0] cnt;
  // flags rise delay_i cycles after arming and hold until software acks
  always @(posedge core_clk_i) begin
    if (srst_i || ack_i) begin
      cnt <= 4'h0;
      flag_o <= '0;
    end else if (arm_i) begin
      cnt <= delay_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) flag_o <= flag_o | which_i;
    end
  end
endmodule
`default_nettype wire

// file: watchdog_sleep_wakeup_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsc_regs.svh"
module watchdog_sleep_wakeup_control_tb_top
  import wdsc_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, pin_n = 1'b1, we = 1'b0, re = 1'b0;
  logic sop = 1'b0, cop = 1'b0, global_irq_enable = 1'b0, arm = 1'b0, ack = 1'b0;
  logic [7:0] cfg = 8'hFF, wd = 8'h00, q, q2, rdata, opt;
  logic [13:0] ad = 14'h0000;
  logic [12:0] pc = 13'h0000, pcv = 13'h0000, vaddr, pf;
  logic [3:0] dly = 4'h1;
  wdsc_irq_s en = '0, src = '0, fl;
  logic crst, pout, poe, osc, hold, slp, wk, vreq, tof, pdf;
  int n_fail = 0, checks = 0, n, rst_cnt = 0, wk_cnt = 0;
  always #50 clk = ~clk;
  wdsc_top #(.TIMEOUT_CYCLES(8)) dut (.core_clk_i(clk), .srst_i(srst),
    .master_reset_pin_n_i(pin_n), .cfg_word_i(cfg), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .sleep_op_i(sop),
    .clear_supervisor_op_i(cop), .pc_i(pc), .irq_enable_i(en), .irq_flag_i(fl),
    .global_irq_enable_i(global_irq_enable), .core_reset_o(crst), .reset_pin_out_o(pout),
    .reset_pin_oe_o(poe), .osc_driver_en_o(osc), .io_hold_o(hold), .sleeping_o(slp),
    .wake_o(wk), .irq_vector_req_o(vreq), .vector_addr_o(vaddr), .prefetch_addr_o(pf),
    .timeout_flag_n_o(tof), .powerdown_flag_n_o(pdf), .option_o(opt));
  wdsc_irq_src u_src (.core_clk_i(clk), .srst_i(srst), .arm_i(arm), .ack_i(ack),
    .delay_i(dly), .which_i(src), .flag_o(fl));
  // count reset and wake pulses between scenario checkpoints
  always @(posedge clk) begin
    rst_cnt += int'(crst === 1'b1);
    wk_cnt += int'(wk === 1'b1);
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [13:0] a, output logic [7:0] d);
    @(posedge clk);
    ad <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic op(input bit is_sleep, input bit do_arm);
    @(posedge clk);
    pc <= pcv;
    arm <= do_arm;
    if (is_sleep) sop <= 1'b1;
    else cop <= 1'b1;
    @(posedge clk);
    sop <= 1'b0;
    cop <= 1'b0;
    arm <= 1'b0;
    #1;
  endtask
  // bounded wait for a reset pulse or a wake pulse
  task automatic wt(input bit on_rst, output int c);
    c = 0;
    while ((on_rst ? crst : wk) !== 1'b1) begin
      @(posedge clk);
      #1;
      c++;
      if (c > 1100) begin
        n_fail++;
        results();
      end
    end
  endtask
  task automatic ackq();
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
  endtask
  initial begin
    void'($urandom(36));
    cfg = 8'($urandom()) | 8'h04;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(`WDSC_OPTION_OFS, q); chk(q, `WDSC_OPTION_RST);
    rd(`WDSC_STATUS_OFS, q); chk(q, 8'h18); // power-on flags
    wr(`WDSC_CONFIG_OFS, ~cfg);
    rd(`WDSC_CONFIG_OFS, q); chk(q, cfg);
    rd(14'h0155, q); chk(q, 8'h00);
    q = 8'($urandom()) | 8'h0C;
    wr(`WDSC_OPTION_OFS, q);
    rd(`WDSC_OPTION_OFS, q2); chk(q2, q);
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      wr(`WDSC_OPTION_OFS, 8'h08 | 8'(r));
      op(0, 0);
      wt(1, n);
      chk(n >= (8 << r) - 1 && n <= (8 << r) + 3, 1'b1); // rate
      rd(`WDSC_STATUS_OFS, q); chk(q, 8'h08);
      rd(`WDSC_OPTION_OFS, q); chk(q, 8'hFF);
      chk(opt, 8'hFF);
      chk({pout, poe}, 2'b00);
    end
    $display("test rates done");
    wr(`WDSC_OPTION_OFS, 8'h00);
    rst_cnt = 0;
    repeat (8) begin
      op(0, 0);
      repeat (3) @(posedge clk);
    end
    chk(16'(rst_cnt), 16'h0000);
    pcv = 13'($urandom());
    op(1, 0);
    chk({slp, hold, osc, pdf, tof}, 5'b11001);
    chk(pf, pcv + 13'h0001);
    wt(0, n);
    chk({n <= 10, crst, slp, vreq}, 4'b1000);
    rd(`WDSC_STATUS_OFS, q); chk(q, 8'h00);
    $display("test supervisor wake done");
    for (int i = 0; i < 6; i++) begin
      wr(`WDSC_OPTION_OFS, 8'hFF);
      @(posedge clk);
      en <= wdsc_irq_s'(3'(1 << (i % 3)));
      src <= wdsc_irq_s'(3'(1 << (i % 3)));
      global_irq_enable <= 1'(i / 3);
      dly <= 4'($urandom_range(6, 1));
      op(0, 0);
      // the word after sleep is treated as a no-op by this core model
      op(1, 1);
      wt(0, n);
      chk({slp, vreq, 4'(n)}, {1'b0, global_irq_enable, dly + 4'h1});
      chk(vaddr, `WDSC_IRQ_VECTOR);
      rd(`WDSC_STATUS_OFS, q); chk(q, 8'h10);
      ackq();
    end
    $display("test irq wake done");
    @(posedge clk) en <= '0;
    op(1, 1);
    repeat (20) @(posedge clk);
    #1;
    chk(slp, 1'b1);
    wk_cnt = 0;
    rst_cnt = 0;
    @(posedge clk) pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({slp, wk_cnt != 0, rst_cnt != 0}, 3'b001);
    rd(`WDSC_STATUS_OFS, q); chk(q, 8'h10);
    ackq();
    op(0, 0);
    // flag must be up before sleep is taken, so the delay is fixed at one
    @(posedge clk) en <= src;
    dly <= 4'h1;
    op(0, 1);
    op(1, 0);
    chk({slp, pdf, tof}, 3'b011);
    ackq();
    $display("test pin reset and pending done");
    // a fast unassigned rate would expire in eight cycles if the enable were ignored
    cfg <= cfg & 8'hFB;
    wr(`WDSC_OPTION_OFS, 8'h00);
    rst_cnt = 0;
    repeat (30) @(posedge clk);
    chk(16'(rst_cnt), 16'h0000);
    $display("test supervisor disable done");
    results();
  end
endmodule
`default_nettype wire
